// [isp_pkg.sv]
// Shared constants for the IMU serial register and burst port.
// Assumes a 20 MHz core clock; register indexes are byte address >> 1.
package isp_pkg;
  ////////////////////////////////////////////////////////////////////
  // Frame and commands
  localparam int ISP_WORD_W = 16;
  localparam logic [15:0] ISP_BURST_CMD = 16'h6800;
  localparam int ISP_NREG = 32;
  ////////////////////////////////////////////////////////////////////
  // Register indexes (byte address >> 1)
  localparam logic [5:0] ISP_IDX_DIAG = 6'h01;
  localparam logic [5:0] ISP_IDX_GYRO = 6'h02;
  localparam logic [5:0] ISP_IDX_ACCL = 6'h08;
  localparam logic [5:0] ISP_IDX_TEMP = 6'h0e;
  localparam logic [5:0] ISP_IDX_SYNC = 6'h0f;
  localparam logic [5:0] ISP_IDX_CNTR = 6'h10;
  localparam logic [5:0] ISP_IDX_DANG = 6'h14;
  localparam logic [5:0] ISP_IDX_DVEL = 6'h1a;
  localparam logic [5:0] ISP_IDX_FILT = 6'h2e;
  localparam logic [5:0] ISP_IDX_MISC = 6'h30;
  localparam logic [5:0] ISP_IDX_DEC = 6'h32;
  localparam logic [5:0] ISP_IDX_FWREV = 6'h36;
  ////////////////////////////////////////////////////////////////////
  // Control fields and reset values
  localparam int ISP_MISC_POL = 0;
  localparam int ISP_MISC_MODE_LSB = 2;
  localparam logic [2:0] ISP_MODE_SCALED = 3'h2;
  localparam int ISP_MISC_SEL = 8;
  localparam int ISP_MISC_WIDE = 9;
  localparam logic [15:0] ISP_MISC_RST = 16'h0001;
  localparam logic [15:0] ISP_DEC_RST = 16'h0000;
  localparam logic [15:0] ISP_FILT_RST = 16'h0000;
  localparam logic [15:0] ISP_FW_MIN = 16'h0134;
  localparam logic [4:0] ISP_LEN_NARROW = 5'h0a;
  localparam logic [4:0] ISP_LEN_WIDE = 5'h10;
  ////////////////////////////////////////////////////////////////////
  // Timing
  localparam int ISP_MCLK_NS = 50;
  localparam int ISP_DR_NS = 200;
  localparam int ISP_DR_CYC = (ISP_DR_NS + ISP_MCLK_NS - 1) / ISP_MCLK_NS;
  localparam int ISP_SCLK_HALF_NS = 500;
  localparam int ISP_HALF_CYC = (ISP_SCLK_HALF_NS + ISP_MCLK_NS - 1) / ISP_MCLK_NS;
  localparam int ISP_GAP_NS = 400;
  localparam int ISP_GAP_CYC = (ISP_GAP_NS + ISP_MCLK_NS - 1) / ISP_MCLK_NS;
endpackage

// [isp_link_if.sv]
// Serial link between the IMU port and its host.
// Host drives clock, select and data in; no clocking block.
`timescale 1ns/100ps
interface isp_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic sample_ready_pulse;
  modport device (input sclk, input cs_n, input mosi, output miso,
    output sample_ready_pulse);
  modport host (output sclk, output cs_n, output mosi, input miso,
    input sample_ready_pulse);
endinterface

// [isp_device.sv]
// Device end: register file, decimation, data ready and burst engine.
// Assumes the link clock runs only inside frames, mode 3, host-made.
//
// Summary of operation
// - Decimation divides update rate by sample count
// - Registers are two bytes, each addressed
// - Peripheral only, mode 3 clocking
// - Sixteen-bit frames, most significant bit first
// - Data ready pulses on every output update
// - Control bit 0 selects pulse polarity
// - Host tolerates ready glitches after reset
// - Read answers in the following frame
// - Read word: bit15 zero, address, don't-care
// - Full duplex: request in, response out
// - Command 0x6800 starts a burst
// - Select held low for whole burst
// - Burst ends with counter then checksum
// - Scaled sync puts sync_a instead
// - Wide burst needs revision 1.34 or later
// - Narrow burst rate and accel words
// - Host disables g compensation in narrow
// - Narrow burst with increment words
// - Checksum sums all preceding bytes
// - Write frames: low byte then high
// - Wide burst: low then upper words
`timescale 1ns/100ps
module isp_device #(
  parameter logic [15:0] FW_REV = 16'h0134 // Revision 1.34, the lowest that enables wide burst and content select
) (
  // Core clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Sensor side
  input wire logic sample_strobe_in,
  input wire logic [15:0] sensor_regs_in [isp_pkg::ISP_NREG],
  // Status and configuration
  output logic update_out,
  output logic [15:0] misc_control_out,
  output logic [15:0] decimation_out,
  output logic [15:0] filter_control_out,
  // Link
  isp_link_if.device link
);
  ////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [15:0] byte_sum(input logic [15:0] w);
    byte_sum = 16'(w[15:8]) + 16'(w[7:0]);
  endfunction

  function automatic logic [15:0] wr_byte(input logic [15:0] old,
    input logic hi, input logic [7:0] d);
    wr_byte = hi ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  // Slot kind: 00 register, 01 checksum, 10 past the end
  function automatic logic [7:0] burst_slot(input logic [4:0] k,
    input logic wide, input logic sel, input logic scaled);
    logic [5:0] gb;
    logic [5:0] ab;
    logic [4:0] n;
    gb = sel ? isp_pkg::ISP_IDX_DANG : isp_pkg::ISP_IDX_GYRO;
    ab = sel ? isp_pkg::ISP_IDX_DVEL : isp_pkg::ISP_IDX_ACCL;
    n = wide ? isp_pkg::ISP_LEN_WIDE : isp_pkg::ISP_LEN_NARROW;
    if (k >= n) begin
      burst_slot = 8'h80;
    end else if (k == n - 5'h01) begin
      burst_slot = 8'h40;
    end else if (k == n - 5'h02) begin
      burst_slot = {2'b00, scaled ? isp_pkg::ISP_IDX_SYNC
        : isp_pkg::ISP_IDX_CNTR};
    end else if (k == n - 5'h03) begin
      burst_slot = {2'b00, isp_pkg::ISP_IDX_TEMP};
    end else if (k == 5'h00) begin
      burst_slot = {2'b00, isp_pkg::ISP_IDX_DIAG};
    end else if (wide) begin
      // Low word then upper word per axis
      burst_slot = {2'b00, (k <= 5'h06) ? gb + 6'(k - 5'h01)
        : ab + 6'(k - 5'h07)};
    end else begin
      // Upper words only, skipping the low words
      burst_slot = {2'b00, (k <= 5'h03) ? gb + 6'({k - 5'h01, 1'b1})
        : ab + 6'({k - 5'h04, 1'b1})};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Link domain: shift in on rising, out on falling edges
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [15:0] rx_sh;
  logic [15:0] next_rx_sh;
  logic in_burst;
  logic next_in_burst;
  logic req_tog;
  logic next_req_tog;
  logic req_is_next;
  logic next_req_is_next;
  logic [15:0] cmd_word;
  logic [15:0] next_cmd_word;
  logic [15:0] tx_sh;
  logic miso;
  logic [15:0] rsp;

  // Frame decode; burst word requested early to give the core time
  always_comb begin
    next_bit_cnt = bit_cnt + 4'h1;
    next_rx_sh = {rx_sh[14:0], link.mosi};
    next_in_burst = in_burst;
    next_req_tog = req_tog;
    next_req_is_next = req_is_next;
    next_cmd_word = cmd_word;
    if (bit_cnt == 4'hf && !in_burst) begin
      next_cmd_word = next_rx_sh;
      next_req_tog = ~req_tog;
      next_req_is_next = 1'b0;
      if (next_rx_sh == isp_pkg::ISP_BURST_CMD) begin
        next_in_burst = 1'b1;
      end
    end else if (bit_cnt == 4'h0 && in_burst) begin
      next_req_tog = ~req_tog;
      next_req_is_next = 1'b1;
    end
  end

  // Select high clears the frame state and ends any burst
  always_ff @(posedge link.sclk or posedge link.cs_n or posedge reset_in) begin
    if (reset_in || link.cs_n) begin
      bit_cnt <= 4'h0;
      rx_sh <= 16'h0000;
      in_burst <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      rx_sh <= next_rx_sh;
      in_burst <= next_in_burst;
    end
  end

  // Request handshake survives select going high
  always_ff @(posedge link.sclk or posedge reset_in) begin
    if (reset_in) begin
      req_tog <= 1'b0;
      req_is_next <= 1'b0;
      cmd_word <= 16'h0000;
    end else begin
      req_tog <= next_req_tog;
      req_is_next <= next_req_is_next;
      cmd_word <= next_cmd_word;
    end
  end

  // Response held still by the core since the request; loaded at bit count 0
  always_ff @(negedge link.sclk or posedge link.cs_n or posedge reset_in) begin
    if (reset_in || link.cs_n) begin
      tx_sh <= 16'h0000;
      miso <= 1'b0;
    end else if (bit_cnt == 4'h0) begin
      tx_sh <= {rsp[14:0], 1'b0};
      miso <= rsp[15];
    end else begin
      tx_sh <= {tx_sh[14:0], 1'b0};
      miso <= tx_sh[15];
    end
  end

  assign link.miso = miso;

  ////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers
  logic req_s1;
  logic req_s2;
  logic cs_s1;
  logic cs_s2;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
    end else begin
      req_s1 <= req_tog;
      req_s2 <= req_s1;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Core domain: decimated output update and data ready
  logic [15:0] out_regs [isp_pkg::ISP_NREG];
  logic [15:0] next_out_regs [isp_pkg::ISP_NREG];
  logic [15:0] cntr;
  logic [15:0] next_cntr;
  logic [15:0] dec_cnt;
  logic [15:0] next_dec_cnt;
  logic [7:0] dr_cnt;
  logic [7:0] next_dr_cnt;
  logic dr_pin;
  logic next_dr_pin;
  logic upd;
  logic next_upd;
  logic [15:0] misc;
  logic [15:0] dec;

  // One update per dec+1 incoming samples
  always_comb begin
    next_out_regs = out_regs;
    next_cntr = cntr;
    next_dec_cnt = dec_cnt;
    next_upd = 1'b0;
    next_dr_cnt = (dr_cnt != 8'h00) ? dr_cnt - 8'h01 : 8'h00;
    if (sample_strobe_in) begin
      if (dec_cnt >= dec) begin
        next_dec_cnt = 16'h0000;
        next_upd = 1'b1;
        next_cntr = cntr + 16'h0001;
        next_out_regs = sensor_regs_in;
        next_out_regs[isp_pkg::ISP_IDX_CNTR[4:0]] = cntr + 16'h0001;
        next_dr_cnt = 8'(isp_pkg::ISP_DR_CYC);
      end else begin
        next_dec_cnt = dec_cnt + 16'h0001;
      end
    end
    // Pulse idles opposite to its collection edge
    next_dr_pin = misc[isp_pkg::ISP_MISC_POL] ^ (next_dr_cnt != 8'h00);
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      out_regs <= '{default: 16'h0000};
      cntr <= 16'h0000;
      dec_cnt <= 16'h0000;
      dr_cnt <= 8'h00;
      dr_pin <= isp_pkg::ISP_MISC_RST[isp_pkg::ISP_MISC_POL];
      upd <= 1'b0;
    end else begin
      out_regs <= next_out_regs;
      cntr <= next_cntr;
      dec_cnt <= next_dec_cnt;
      dr_cnt <= next_dr_cnt;
      dr_pin <= next_dr_pin;
      upd <= next_upd;
    end
  end

  assign link.sample_ready_pulse = dr_pin;
  assign update_out = upd;

  ////////////////////////////////////////////////////////////////////
  // Core domain: request service, writes and burst words
  localparam logic FW_OK = (FW_REV >= isp_pkg::ISP_FW_MIN);
  logic [15:0] next_rsp;
  logic [4:0] bidx;
  logic [4:0] next_bidx;
  logic [15:0] bsum;
  logic [15:0] next_bsum;
  logic bact;
  logic next_bact;
  logic req_seen;
  logic [15:0] next_misc;
  logic [15:0] next_dec;
  logic [15:0] filt;
  logic [15:0] next_filt;

  // Burst words are served live, so an update may land mid-burst
  always_comb begin
    logic [7:0] slot;
    logic [4:0] k;
    logic [15:0] base;
    logic [15:0] word;
    logic [5:0] ridx;
    slot = 8'h00;
    k = 5'h00;
    base = 16'h0000;
    word = 16'h0000;
    ridx = cmd_word[14:9];
    next_rsp = rsp;
    next_bidx = bidx;
    next_bsum = bsum;
    next_bact = bact;
    next_misc = misc;
    next_dec = dec;
    next_filt = filt;
    if (req_s2 != req_seen) begin
      if (req_is_next || cmd_word == isp_pkg::ISP_BURST_CMD) begin
        k = req_is_next ? bidx : 5'h00;
        base = req_is_next ? bsum : 16'h0000;
        // Wide and content select only on newer revisions
        slot = burst_slot(k, FW_OK & misc[isp_pkg::ISP_MISC_WIDE],
          FW_OK & misc[isp_pkg::ISP_MISC_SEL],
          misc[isp_pkg::ISP_MISC_MODE_LSB +: 3] == isp_pkg::ISP_MODE_SCALED);
        if (!req_is_next || bact) begin
          word = (slot[7:6] == 2'b01) ? base : out_regs[slot[4:0]];
        end
        if (slot[7]) begin
          word = 16'h0000;
        end
        next_rsp = word;
        next_bact = 1'b1;
        next_bsum = base + byte_sum(word);
        next_bidx = slot[7] ? k : k + 5'h01;
      end else if (cmd_word[15]) begin
        // Each byte lands alone; low byte expected first
        case (ridx)
          isp_pkg::ISP_IDX_MISC: next_misc = wr_byte(misc, cmd_word[8],
            cmd_word[7:0]);
          isp_pkg::ISP_IDX_DEC: next_dec = wr_byte(dec, cmd_word[8], cmd_word[7:0]);
          isp_pkg::ISP_IDX_FILT: next_filt = wr_byte(filt, cmd_word[8], cmd_word[7:0]);
          default: next_misc = misc;
        endcase
      end else begin
        // Either byte address yields the whole word
        case (ridx)
          isp_pkg::ISP_IDX_MISC: next_rsp = misc;
          isp_pkg::ISP_IDX_DEC: next_rsp = dec;
          isp_pkg::ISP_IDX_FILT: next_rsp = filt;
          isp_pkg::ISP_IDX_FWREV: next_rsp = FW_REV;
          default: next_rsp = ridx[5] ? 16'h0000 : out_regs[ridx[4:0]];
        endcase
      end
    end else if (cs_s2) begin
      next_bact = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rsp <= 16'h0000;
      bidx <= 5'h00;
      bsum <= 16'h0000;
      bact <= 1'b0;
      req_seen <= 1'b0;
      misc <= isp_pkg::ISP_MISC_RST;
      dec <= isp_pkg::ISP_DEC_RST;
      filt <= isp_pkg::ISP_FILT_RST;
    end else begin
      rsp <= next_rsp;
      bidx <= next_bidx;
      bsum <= next_bsum;
      bact <= next_bact;
      req_seen <= req_s2;
      misc <= next_misc;
      dec <= next_dec;
      filt <= next_filt;
    end
  end

  assign misc_control_out = misc;
  assign decimation_out = dec;
  assign filter_control_out = filt;
endmodule // isp_device

// [isp_host.sv]
// Host end: mode 3 frame master with clock divider and ready edge.
// Assumes user requests only while ready_out is high.
`timescale 1ns/100ps
module isp_host #(
  parameter int HALF_CYC = isp_pkg::ISP_HALF_CYC,
  parameter int GAP_CYC = isp_pkg::ISP_GAP_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // User request
  input wire logic req_in,
  input wire logic [15:0] tx_word_in,
  input wire logic hold_cs_in,
  input wire logic drdy_polarity_in,
  // User answer
  output logic ready_out,
  output logic done_out,
  output logic [15:0] rx_word_out,
  output logic sum_ok_out,
  output logic drdy_event_out,
  // Link
  isp_link_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_GAP = 3'b100
  } isp_hstate_t;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic m1;
  logic m2;
  logic d1;
  logic d2;
  logic d3;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      m1 <= 1'b0;
      m2 <= 1'b0;
      // Idle level of the ready pin, so no false edge follows reset
      d1 <= 1'b1;
      d2 <= 1'b1;
      d3 <= 1'b1;
    end else begin
      m1 <= link.miso;
      m2 <= m1;
      d1 <= link.sample_ready_pulse;
      d2 <= d1;
      d3 <= d2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame engine
  isp_hstate_t st;
  isp_hstate_t next_st;
  logic [7:0] tmr;
  logic [7:0] next_tmr;
  logic [3:0] bit_n;
  logic [3:0] next_bit_n;
  logic [15:0] tx_sh;
  logic [15:0] next_tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] next_rx_sh;
  logic [15:0] cur_tx;
  logic [15:0] next_cur_tx;
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic hold;
  logic next_hold;
  logic sclk;
  logic next_sclk;
  logic cs_n;
  logic next_cs_n;
  logic mosi;
  logic next_mosi;
  logic next_ready;
  logic next_done;
  logic [15:0] next_rx_word;
  logic next_sum_ok;
  logic next_drdy;

  // Divider paces both halves; miso taken just before each rise
  always_comb begin
    next_st = st;
    next_tmr = (tmr != 8'h00) ? tmr - 8'h01 : 8'h00;
    next_bit_n = bit_n;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_cur_tx = cur_tx;
    next_acc = acc;
    next_hold = hold;
    next_sclk = sclk;
    next_cs_n = cs_n;
    next_mosi = mosi;
    next_ready = ready_out;
    next_done = 1'b0;
    next_rx_word = rx_word_out;
    next_sum_ok = sum_ok_out;
    next_drdy = drdy_polarity_in ? (d2 & ~d3) : (~d2 & d3);
    case (st)
      H_IDLE: begin
        if (req_in) begin
          next_st = H_LEAD;
          next_tmr = 8'(HALF_CYC - 1);
          next_cs_n = 1'b0;
          next_tx_sh = tx_word_in;
          next_cur_tx = tx_word_in;
          next_hold = hold_cs_in;
          next_ready = 1'b0;
        end
      end
      H_LEAD, H_HIGH: begin
        if (tmr == 8'h00) begin
          if (st == H_HIGH && bit_n == 4'h0) begin
            next_st = H_GAP;
            next_tmr = 8'(GAP_CYC - 1);
            next_cs_n = ~hold;
            next_done = 1'b1;
            next_rx_word = rx_sh;
            next_sum_ok = (rx_sh == acc);
            // Byte sum restarts on each burst command
            next_acc = (cur_tx == isp_pkg::ISP_BURST_CMD) ? 16'h0000
              : acc + 16'(rx_sh[15:8]) + 16'(rx_sh[7:0]);
          end else begin
            next_st = H_LOW;
            next_tmr = 8'(HALF_CYC - 1);
            next_sclk = 1'b0;
            next_mosi = tx_sh[15];
            next_tx_sh = {tx_sh[14:0], 1'b0};
          end
        end
      end
      H_LOW: begin
        if (tmr == 8'h00) begin
          next_st = H_HIGH;
          next_tmr = 8'(HALF_CYC - 1);
          next_sclk = 1'b1;
          next_rx_sh = {rx_sh[14:0], m2};
          next_bit_n = bit_n + 4'h1;
        end
      end
      H_GAP: begin
        if (tmr == 8'h00) begin
          next_st = H_IDLE;
          next_ready = 1'b1;
        end
      end
      default: next_st = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= H_IDLE;
      tmr <= 8'h00;
      bit_n <= 4'h0;
      tx_sh <= 16'h0000;
      rx_sh <= 16'h0000;
      cur_tx <= 16'h0000;
      acc <= 16'h0000;
      hold <= 1'b0;
      sclk <= 1'b1;
      cs_n <= 1'b1;
      mosi <= 1'b0;
      ready_out <= 1'b1;
      done_out <= 1'b0;
      rx_word_out <= 16'h0000;
      sum_ok_out <= 1'b0;
      drdy_event_out <= 1'b0;
    end else begin
      st <= next_st;
      tmr <= next_tmr;
      bit_n <= next_bit_n;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      cur_tx <= next_cur_tx;
      acc <= next_acc;
      hold <= next_hold;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      mosi <= next_mosi;
      ready_out <= next_ready;
      done_out <= next_done;
      rx_word_out <= next_rx_word;
      sum_ok_out <= next_sum_ok;
      drdy_event_out <= next_drdy;
    end
  end

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.mosi = mosi;
endmodule // isp_host

// [isp_link_properties.sv]
// Checker for the serial link between the IMU port and its host.
// Assumes the link wires are flops of the core clock domain.
`timescale 1ns/100ps
module isp_link_properties #(
  parameter int HALF_CYC = isp_pkg::ISP_HALF_CYC
) (
  // Core clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sample_ready_pulse
);
  default clocking dflt_cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  // Serial clock falls modulo sixteen; a frame must end on a whole word
  logic sclk_q;
  logic next_sclk_q;
  logic [3:0] fall_cnt;
  logic [3:0] next_fall_cnt;
  always_comb begin
    next_sclk_q = sclk;
    next_fall_cnt = fall_cnt + {3'h0, sclk_q & ~sclk};
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sclk_q <= 1'b1;
      fall_cnt <= 4'h0;
    end else begin
      sclk_q <= next_sclk_q;
      fall_cnt <= next_fall_cnt;
    end
  end
  ////////////////////////////////////////
  chk_idle_clock_high: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  chk_select_lead: assert property ($fell(cs_n) |-> sclk [*8])
    else $error("serial clock fell too soon after select");
  chk_half_period: assert property ($fell(sclk) |-> ##HALF_CYC $rose(sclk))
    else $error("serial clock low half has wrong length");
  chk_word_length: assert property ($rose(cs_n) |-> fall_cnt == 4'h0)
    else $error("frame ended on a partial word");
  chk_miso_on_fall: assert property (!cs_n && $changed(miso) |-> $fell(sclk))
    else $error("device data changed off a falling clock");
  chk_mosi_on_fall: assert property (!cs_n && $changed(mosi) |-> $fell(sclk))
    else $error("host data changed off a falling clock");
  chk_miso_released: assert property (cs_n |-> !miso)
    else $error("device data driven while deselected");
  chk_ready_width: assert property ($changed(sample_ready_pulse) |=>
    $stable(sample_ready_pulse) [*3])
    else $error("data ready pulse too short");
  chk_select_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select idle time too short");
  cover property ($fell(sample_ready_pulse));
  cover property ($rose(cs_n));
  cover property (!cs_n && $fell(sclk) && miso);
endmodule // isp_link_properties

// [imu_spi_register_burst_port_tb.sv]
// Bench: host end and device end joined by the link interface.
// Assumes one 20 MHz core clock shared by both ends.
`timescale 1ns/100ps
module imu_spi_register_burst_port_tb;
  typedef logic [17:0] isp_exp_t; // Check word, check sum flag, value
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sample_strobe_in = 1'b0;
  logic req_in = 1'b0;
  logic hold_cs_in = 1'b0;
  logic drdy_polarity_in = 1'b1;
  logic [15:0] tx_word_in = 16'h0000;
  logic [15:0] regs [isp_pkg::ISP_NREG];
  logic update_out, ready_out, done_out, sum_ok_out, drdy_event_out;
  logic [15:0] misc_out, dec_out, filt_out, rx_word_out, mosi_sr, miso_sr;
  int num_errors = 0, compares = 0, upd_n = 0, evt_n = 0, cnt = 0;
  isp_exp_t exp_q[$];
  isp_exp_t pend = 18'h0;
  logic [15:0] tx_q[$];
  isp_link_if isp_link_if_i ();
  always #25 mclk_in = ~mclk_in;
  isp_device isp_device_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .sample_strobe_in(sample_strobe_in), .sensor_regs_in(regs), .update_out(update_out),
    .misc_control_out(misc_out), .decimation_out(dec_out), .filter_control_out(filt_out),
    .link(isp_link_if_i));
  isp_host isp_host_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .req_in(req_in), .tx_word_in(tx_word_in), .hold_cs_in(hold_cs_in),
    .drdy_polarity_in(drdy_polarity_in), .ready_out(ready_out), .done_out(done_out),
    .rx_word_out(rx_word_out), .sum_ok_out(sum_ok_out), .drdy_event_out(drdy_event_out),
    .link(isp_link_if_i));
  isp_link_properties isp_link_properties_i (.mclk_in(mclk_in),
    .reset_in(reset_in), .sclk(isp_link_if_i.sclk), .cs_n(isp_link_if_i.cs_n),
    .mosi(isp_link_if_i.mosi), .miso(isp_link_if_i.miso),
    .sample_ready_pulse(isp_link_if_i.sample_ready_pulse));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] ex, input logic [15:0] sn);
    compares++;
    if (sn !== ex) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One frame; nx is the reply due in the frame after this one
  task automatic frame(input logic [15:0] w, input logic h, input isp_exp_t nx);
    while (ready_out !== 1'b1) @(posedge mclk_in) #1;
    req_in = 1'b1;
    tx_word_in = w;
    hold_cs_in = h;
    exp_q.push_back(pend);
    tx_q.push_back(w);
    pend = nx;
    @(posedge mclk_in) #1;
    req_in = 1'b0;
  endtask
  task automatic settle();
    while (exp_q.size() != 0 || ready_out !== 1'b1) @(posedge mclk_in) #1;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    frame({1'b1, a, v[7:0]}, 1'b0, 18'h0);
    frame({1'b1, a + 7'h01, v[15:8]}, 1'b0, 18'h0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] v);
    frame({1'b0, a, 8'h00}, 1'b0, {2'b10, v});
  endtask
  task automatic strobe(input int n);
    repeat (n) begin
      sample_strobe_in = 1'b1;
      @(posedge mclk_in) #1;
      sample_strobe_in = 1'b0;
      repeat (12) @(posedge mclk_in) #1;
    end
  endtask
  // Burst; a nonzero last cuts it short by raising select
  task automatic burst(input logic sel, input logic wide, input logic scl, input int last);
    isp_exp_t ent[$];
    logic [15:0] s;
    int rb;
    int ab;
    rb = sel ? 20 : 2;
    ab = sel ? 26 : 8;
    ent.push_back({2'b10, regs[isp_pkg::ISP_IDX_DIAG]});
    for (int i = 0; i < 12; i++)
      if (wide || i % 2 == 1) ent.push_back({2'b10, regs[(i < 6 ? rb : ab) + i % 6]});
    ent.push_back({2'b10, regs[isp_pkg::ISP_IDX_TEMP]});
    ent.push_back({2'b10, scl ? regs[isp_pkg::ISP_IDX_SYNC] : cnt[15:0]});
    s = 16'h0000;
    foreach (ent[i]) s += ent[i][15:8] + ent[i][7:0];
    ent.push_back({2'b11, s});
    ent.push_back(18'h0);
    if (last == 0) last = ent.size() - 1;
    frame(isp_pkg::ISP_BURST_CMD, 1'b1, ent[0]);
    for (int k = 1; k <= last; k++) frame(16'h0000, k < last, k < last ? ent[k] : 18'h0);
  endtask
  ////////////////////////////////////////
  // Bits on the wire, captured at each rising serial clock
  always @(posedge isp_link_if_i.sclk) begin
    if (isp_link_if_i.cs_n === 1'b0) begin
      mosi_sr <= {mosi_sr[14:0], isp_link_if_i.mosi};
      miso_sr <= {miso_sr[14:0], isp_link_if_i.miso};
    end
  end
  // Watcher: oldest note against each completed frame
  always @(posedge mclk_in) begin
    if (update_out === 1'b1) upd_n++;
    if (drdy_event_out === 1'b1) evt_n++;
    if (done_out === 1'b1) begin
      check("mosi bits", tx_q[0], mosi_sr);
      if (exp_q[0][17]) check("reply", exp_q[0][15:0], rx_word_out);
      if (exp_q[0][17]) check("miso bits", exp_q[0][15:0], miso_sr);
      if (exp_q[0][16]) check("sum flag", 16'h0001, {15'h0, sum_ok_out});
      exp_q.delete(0);
      tx_q.delete(0);
    end
  end
  // Watchdog well above the expected fifty thousand cycles
  initial begin
    #(50 * 90000);
    num_errors++;
    end_of_test();
  end
  initial begin
    logic [15:0] mv;
    void'($urandom(11));
    foreach (regs[i]) regs[i] = 16'($urandom());
    repeat (20) @(posedge mclk_in);
    #1 reset_in = 1'b0;
    // Reset values and back to back reads, either byte address
    rd(7'h60, isp_pkg::ISP_MISC_RST);
    rd(7'h65, isp_pkg::ISP_DEC_RST);
    rd(7'h5c, isp_pkg::ISP_FILT_RST);
    rd(7'h6d, 16'h0134);
    // Output image is zero until the first update latches it
    strobe(1);
    rd(7'h1d, regs[isp_pkg::ISP_IDX_TEMP]);
    rd(7'h1c, regs[isp_pkg::ISP_IDX_TEMP]);
    // One update per three samples, earlier ready activity discarded
    wr16(7'h64, 16'h0002);
    wr16(7'h5c, 16'h0004);
    settle();
    check("decimation", 16'h0002, dec_out);
    check("filter control", 16'h0004, filt_out);
    upd_n = 0;
    evt_n = 0;
    strobe(6);
    check("updates", 16'h0002, 16'(upd_n));
    check("ready events", 16'h0002, 16'(evt_n));
    // Inverted ready polarity, one update per sample
    wr16(7'h64, 16'h0000);
    wr16(7'h60, 16'h0000);
    settle();
    drdy_polarity_in = 1'b0;
    repeat (8) @(posedge mclk_in) #1;
    evt_n = 0;
    strobe(3);
    cnt = 6;
    check("ready events", 16'h0003, 16'(evt_n));
    // Every burst layout, with counter or sync_a
    for (int m = 0; m < 8; m++) begin
      mv = {6'h00, m[1], m[0], 4'h0, m[2], 3'h0};
      wr16(7'h60, mv);
      settle();
      check("misc control", mv, misc_out);
      // Fresh sensor image latched before each burst
      foreach (regs[i]) regs[i] = 16'($urandom());
      strobe(1);
      cnt++;
      burst(m[0], m[1], m[2], 0);
    end
    // Burst cut short, then plain decoding again
    burst(1'b1, 1'b1, 1'b1, 3);
    rd(7'h1c, regs[isp_pkg::ISP_IDX_TEMP]);
    frame(16'h0000, 1'b0, 18'h0);
    settle();
    end_of_test();
  end
endmodule // imu_spi_register_burst_port_tb
